/* File: logic/fcd_pkg.sv */
// constants, types and operation summary for the flash command decoder
// Operation
// - address on strobe fall, data on rise
// - decode compares only address bits 11..0
// - read-array mode returns array data, bit 5 forced to 1 while the error flag is set
// - f0 write anywhere returns to read mode, or to bypass mode while bypass is set
// - id sequence aa@555, 55@aaa, 90@555, read
// - id read needs a6,a1,a0 = 0,0,1
// - protection read needs a6,a1,a0 = 0,1,0
// - protection read returns 01 or 00, or 21 or 20 while the error flag is set
// - erase sector chosen by active select
// - extra sector erase within 80 us joins
// - bypass program only inside bypass mode
// - bypass left only by bypass reset
// - suspend honoured only while erase runs
// - resume only honoured while suspended
// - reset leaves read-array mode
// - sequence cycles are writes unless read
// - error flag set on failure, reset clears, but an f0 reset in bypass mode leaves it set
package fcd_pkg;
    localparam int ADDR_W = 16;
    localparam int SECT_W = 12;
    localparam logic [11:0] ADR_555 = 12'h555;
    localparam logic [11:0] ADR_AAA = 12'haaa;
    localparam logic [7:0] DAT_UNLOCK1 = 8'haa;
    localparam logic [7:0] DAT_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] CMD_RESET = 8'hf0;
    localparam logic [7:0] CMD_PROGRAM = 8'ha0;
    localparam logic [7:0] CMD_ERASE_SETUP = 8'h80;
    localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
    localparam logic [7:0] CMD_BULK_ERASE = 8'h10;
    localparam logic [7:0] CMD_BYPASS = 8'h20;
    localparam logic [7:0] CMD_BYPASS_RST = 8'h00;
    localparam logic [7:0] CMD_SUSPEND = 8'hb0;
    localparam logic [7:0] CMD_RESUME = 8'h30;
    localparam logic [7:0] PROT_YES = 8'h01;
    localparam logic [7:0] PROT_NO = 8'h00;
    localparam logic [2:0] SEL_ID = 3'b001;
    localparam logic [2:0] SEL_PROT = 3'b010;
    localparam int ERR_BIT = 5;
    localparam int CLK_MHZ = 100;
    localparam int ERASE_WIN_US = 80;
    localparam int ERASE_WIN_CYC = ERASE_WIN_US * CLK_MHZ;
    localparam int WIN_W = 14;

    typedef enum {
        FCD_READ, FCD_U1, FCD_U2, FCD_ID, FCD_PROG, FCD_E1, FCD_E2, FCD_E3,
        FCD_E4, FCD_ERASE, FCD_SUSP, FCD_BYP, FCD_BYP_PROG, FCD_BYP_RST
    } fcd_mode_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [SECT_W-1:0] sel;
        logic [7:0] data;
    } fcd_cycle_t;

    // one request to the array back end
    typedef struct packed {
        logic prog;
        logic erase;
        logic bulk;
        logic [SECT_W-1:0] sectors;
        logic [ADDR_W-1:0] addr;
        logic [7:0] data;
    } fcd_req_t;
endpackage

/* File: logic/fcd_sync.sv */
// two-stage synchroniser for a bus of pin inputs
`timescale 1ns/1ps
module fcd_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } fcd_sync_st_t;
    fcd_sync_st_t st_q;
    fcd_sync_st_t st_d;

    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;
endmodule

/* File: logic/fcd_decoder.sv */
// bus-cycle instruction decoder and read-mode control for the flash array
`timescale 1ns/1ps
module fcd_decoder #(
    parameter int ERASE_WIN = fcd_pkg::ERASE_WIN_CYC,
    parameter logic [7:0] ID_CODE = 8'h5a // arbitrary identifier value
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic WR_N,
    input wire logic RD_N,
    input wire logic [fcd_pkg::ADDR_W-1:0] ADDR,
    input wire logic [7:0] DATA_IN,
    input wire logic [7:0] MAIN_SECTOR_SELECT,
    input wire logic [3:0] SECONDARY_SECTOR_SELECT,
    input wire logic [7:0] ARRAY_DATA,
    input wire logic [fcd_pkg::SECT_W-1:0] PROTECTED,
    input wire logic OP_DONE,
    input wire logic OP_FAIL,
    output fcd_pkg::fcd_req_t REQ,
    output logic REQ_VALID,
    output logic ERASE_GO,
    output logic SUSPEND,
    output logic [7:0] RD_DATA,
    output logic ERROR_FLAG_BIT,
    output logic BYPASS_MODE,
    output logic READ_ARRAY
);
    localparam int SW = fcd_pkg::SECT_W;
    localparam logic [fcd_pkg::WIN_W-1:0] WIN_LAST = fcd_pkg::WIN_W'(ERASE_WIN - 1);

    typedef struct packed {
        fcd_pkg::fcd_mode_t mode;
        logic wr_q;
        logic rd_q;
        fcd_pkg::fcd_cycle_t cyc;
        fcd_pkg::fcd_req_t req;
        logic req_v;
        logic erase_go;
        logic erase_run;
        logic win_open;
        logic [fcd_pkg::WIN_W-1:0] win_cnt;
        logic err;
        logic bypass;
        logic [7:0] rdata;
        logic susp_o;
        logic read_o;
    } fcd_st_t;

    fcd_st_t st_q;
    fcd_st_t st_d;

    logic [1+1+fcd_pkg::ADDR_W+8+SW-1:0] pins_raw;
    logic [1+1+fcd_pkg::ADDR_W+8+SW-1:0] pins;
    logic wr_n_s;
    logic rd_n_s;
    logic wr_on_s;
    logic rd_on_s;
    logic [fcd_pkg::ADDR_W-1:0] addr_s;
    logic [7:0] data_s;
    logic [SW-1:0] sel_s;

    // strobes enter active high so a cleared synchroniser reads as idle
    assign pins_raw = {~WR_N, ~RD_N, ADDR, DATA_IN,
                       SECONDARY_SECTOR_SELECT, MAIN_SECTOR_SELECT};

    ////////////////////////////////////////////////////////////////////////////
    fcd_sync #(
        .W($bits(pins_raw))
    ) u_sync (
        .clk(MCLK),
        .rst(SRST),
        .d(pins_raw),
        .q(pins)
    );

    assign {wr_on_s, rd_on_s, addr_s, data_s, sel_s} = pins;
    assign wr_n_s = ~wr_on_s;
    assign rd_n_s = ~rd_on_s;

    // only the low twelve address bits take part in decode
    function automatic logic hit(input logic [fcd_pkg::ADDR_W-1:0] a, input logic [11:0] ref_a,
                                 input logic [7:0] d, input logic [7:0] ref_d);
        hit = (a[11:0] == ref_a) && (d == ref_d);
    endfunction

    function automatic logic [2:0] bits610(input logic [fcd_pkg::ADDR_W-1:0] a);
        bits610 = {a[6], a[1], a[0]};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    logic wr_fall;
    logic wr_rise;
    logic rd_fall;
    fcd_pkg::fcd_cycle_t c;

    assign wr_fall = st_q.wr_q & ~wr_n_s;
    assign wr_rise = ~st_q.wr_q & wr_n_s;
    assign rd_fall = st_q.rd_q & ~rd_n_s;

    always_comb begin
        st_d = st_q;
        st_d.wr_q = wr_n_s;
        st_d.rd_q = rd_n_s;
        st_d.req_v = 1'b0;
        st_d.erase_go = 1'b0;
        c = st_q.cyc;
        c.data = data_s;
        if (wr_fall) begin
            st_d.cyc.addr = addr_s;
            st_d.cyc.sel = sel_s;
        end
        if (OP_DONE) begin
            st_d.erase_run = 1'b0;
        end
        // erase window: further sector erase must land before it closes
        if (st_q.win_open) begin
            if (st_q.win_cnt == WIN_LAST) begin
                st_d.win_open = 1'b0;
                st_d.erase_go = 1'b1;
                st_d.erase_run = 1'b1;
            end else begin
                st_d.win_cnt = st_q.win_cnt + 1'b1;
            end
        end
        // every sequence step is taken on the write-strobe rising edge
        if (wr_rise) begin
            st_d.cyc.data = data_s;
            st_d.mode = fcd_pkg::FCD_READ;
            if (hit(c.addr, 12'h000, c.data, fcd_pkg::CMD_RESET) || c.data == fcd_pkg::CMD_RESET)
            begin
                if (!st_q.bypass) begin
                    st_d.err = 1'b0;
                end
                st_d.mode = st_q.bypass ? fcd_pkg::FCD_BYP : fcd_pkg::FCD_READ;
            end else begin
                case (st_q.mode)
                    fcd_pkg::FCD_READ, fcd_pkg::FCD_SUSP, fcd_pkg::FCD_ERASE: begin
                        if (hit(c.addr, fcd_pkg::ADR_555, c.data, fcd_pkg::DAT_UNLOCK1)) begin
                            st_d.mode = fcd_pkg::FCD_U1;
                        end else if (c.data == fcd_pkg::CMD_SUSPEND && st_q.erase_run
                                     && !st_q.win_open) begin
                            st_d.mode = fcd_pkg::FCD_SUSP;
                        end else if (c.data == fcd_pkg::CMD_RESUME
                                     && st_q.mode == fcd_pkg::FCD_SUSP) begin
                            st_d.mode = fcd_pkg::FCD_ERASE;
                        end else if (st_q.mode == fcd_pkg::FCD_SUSP) begin
                            st_d.mode = fcd_pkg::FCD_SUSP;
                        end else if (st_q.erase_run) begin
                            st_d.mode = fcd_pkg::FCD_ERASE;
                        end
                    end
                    fcd_pkg::FCD_U1: begin
                        if (hit(c.addr, fcd_pkg::ADR_AAA, c.data, fcd_pkg::DAT_UNLOCK2)) begin
                            st_d.mode = fcd_pkg::FCD_U2;
                        end
                    end
                    fcd_pkg::FCD_U2: begin
                        if (hit(c.addr, fcd_pkg::ADR_555, c.data, fcd_pkg::CMD_ID)) begin
                            st_d.mode = fcd_pkg::FCD_ID;
                        end else if (hit(c.addr, fcd_pkg::ADR_555, c.data,
                                         fcd_pkg::CMD_PROGRAM)) begin
                            st_d.mode = fcd_pkg::FCD_PROG;
                        end else if (hit(c.addr, fcd_pkg::ADR_555, c.data,
                                         fcd_pkg::CMD_BYPASS) && !st_q.erase_run) begin
                            st_d.mode = fcd_pkg::FCD_BYP;
                            st_d.bypass = 1'b1;
                        end else if (hit(c.addr, fcd_pkg::ADR_555, c.data,
                                         fcd_pkg::CMD_ERASE_SETUP) && !st_q.erase_run) begin
                            st_d.mode = fcd_pkg::FCD_E1;
                        end
                    end
                    fcd_pkg::FCD_ID: begin
                        st_d.mode = fcd_pkg::FCD_ID;
                    end
                    fcd_pkg::FCD_PROG, fcd_pkg::FCD_BYP_PROG: begin
                        // program target must not be the sector under erase
                        if (!(st_q.erase_run && |(c.sel & st_q.req.sectors))) begin
                            st_d.req.prog = 1'b1;
                            st_d.req.erase = 1'b0;
                            st_d.req.addr = c.addr;
                            st_d.req.data = c.data;
                            st_d.req_v = 1'b1;
                        end
                        st_d.mode = st_q.bypass ? fcd_pkg::FCD_BYP
                                  : (st_q.erase_run ? fcd_pkg::FCD_SUSP : fcd_pkg::FCD_READ);
                    end
                    fcd_pkg::FCD_E1: begin
                        if (hit(c.addr, fcd_pkg::ADR_555, c.data, fcd_pkg::DAT_UNLOCK1)) begin
                            st_d.mode = fcd_pkg::FCD_E2;
                        end
                    end
                    fcd_pkg::FCD_E2: begin
                        if (hit(c.addr, fcd_pkg::ADR_AAA, c.data, fcd_pkg::DAT_UNLOCK2)) begin
                            st_d.mode = fcd_pkg::FCD_E3;
                        end
                    end
                    fcd_pkg::FCD_E3, fcd_pkg::FCD_E4: begin
                        if (c.data == fcd_pkg::CMD_SECTOR_ERASE) begin
                            st_d.req.sectors = (st_q.mode == fcd_pkg::FCD_E4)
                                             ? (st_q.req.sectors | c.sel) : c.sel;
                            st_d.req.erase = 1'b1;
                            st_d.req.prog = 1'b0;
                            st_d.req.bulk = 1'b0;
                            st_d.win_open = 1'b1;
                            st_d.win_cnt = '0;
                            st_d.mode = fcd_pkg::FCD_E4;
                        end else if (st_q.mode == fcd_pkg::FCD_E3
                                     && hit(c.addr, fcd_pkg::ADR_555, c.data,
                                            fcd_pkg::CMD_BULK_ERASE)) begin
                            st_d.req.sectors = '1;
                            st_d.req.erase = 1'b1;
                            st_d.req.prog = 1'b0;
                            st_d.req.bulk = 1'b1;
                            st_d.req_v = 1'b1;
                            st_d.erase_run = 1'b1;
                            st_d.mode = fcd_pkg::FCD_ERASE;
                        end else if (st_q.mode == fcd_pkg::FCD_E4) begin
                            st_d.mode = fcd_pkg::FCD_E4;
                        end
                    end
                    fcd_pkg::FCD_BYP: begin
                        // bypass is left only by the bypass reset pair
                        st_d.mode = fcd_pkg::FCD_BYP;
                        if (c.data == fcd_pkg::CMD_PROGRAM) begin
                            st_d.mode = fcd_pkg::FCD_BYP_PROG;
                        end else if (c.data == fcd_pkg::CMD_ID) begin
                            st_d.mode = fcd_pkg::FCD_BYP_RST;
                        end
                    end
                    fcd_pkg::FCD_BYP_RST: begin
                        st_d.mode = fcd_pkg::FCD_BYP;
                        if (c.data == fcd_pkg::CMD_BYPASS_RST) begin
                            st_d.mode = fcd_pkg::FCD_READ;
                            st_d.bypass = 1'b0;
                        end
                    end
                    default: begin
                        st_d.mode = fcd_pkg::FCD_READ;
                    end
                endcase
            end
        end
        // error flag: a failure in the same cycle as a reset instruction wins
        if (OP_FAIL) begin
            st_d.err = 1'b1;
        end
        // while the erase window counts, the mode stays in sector-erase entry unless an f0 reset is written
        if (st_q.mode == fcd_pkg::FCD_E4 && st_q.win_open && st_q.win_cnt == WIN_LAST) begin
            st_d.mode = fcd_pkg::FCD_ERASE;
            st_d.req_v = 1'b1;
        end
        // read data mux: array, identifier or protection status
        if (rd_fall) begin
            st_d.rdata = ARRAY_DATA;
            if (st_q.mode == fcd_pkg::FCD_ID) begin
                if (bits610(addr_s) == fcd_pkg::SEL_ID && |sel_s[7:0]) begin
                    st_d.rdata = ID_CODE;
                end else if (bits610(addr_s) == fcd_pkg::SEL_PROT) begin
                    st_d.rdata = |(sel_s & PROTECTED) ? fcd_pkg::PROT_YES
                                                      : fcd_pkg::PROT_NO;
                end
            end
            st_d.rdata[fcd_pkg::ERR_BIT] = st_q.err ? 1'b1 : st_d.rdata[fcd_pkg::ERR_BIT];
        end
        // mode flags registered so the outputs come straight from flops
        st_d.susp_o = (st_d.mode == fcd_pkg::FCD_SUSP);
        st_d.read_o = (st_d.mode == fcd_pkg::FCD_READ);
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            st_q <= '0;
            st_q.mode <= fcd_pkg::FCD_READ;
            st_q.wr_q <= 1'b1;
            st_q.rd_q <= 1'b1;
            st_q.read_o <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign REQ = st_q.req;
    assign REQ_VALID = st_q.req_v;
    assign ERASE_GO = st_q.erase_go;
    assign SUSPEND = st_q.susp_o;
    assign RD_DATA = st_q.rdata;
    assign ERROR_FLAG_BIT = st_q.err;
    assign BYPASS_MODE = st_q.bypass;
    assign READ_ARRAY = st_q.read_o;

    ////////////////////////////////////////////////////////////////////////////
    sequence s_unlock_done;
        wr_rise && st_q.mode == fcd_pkg::FCD_U2
            && hit(st_q.cyc.addr, fcd_pkg::ADR_555, data_s, fcd_pkg::CMD_ID);
    endsequence

    sequence s_id_read;
        rd_fall && st_q.mode == fcd_pkg::FCD_ID && !st_q.err;
    endsequence

    sequence s_wr_in_read;
        wr_rise && st_q.mode == fcd_pkg::FCD_READ;
    endsequence

    a_reset_read_mode: assert property (@(posedge MCLK) SRST |=> READ_ARRAY)
        else $error("reset did not give read-array mode");
    a_id_entry_seq: assert property (@(posedge MCLK) disable iff (SRST)
        s_unlock_done |=> st_q.mode == fcd_pkg::FCD_ID)
        else $error("id sequence not entered");
    a_reset_cmd_read: assert property (@(posedge MCLK) disable iff (SRST)
        wr_rise && data_s == fcd_pkg::CMD_RESET && !st_q.bypass && !OP_FAIL
        |=> READ_ARRAY && !ERROR_FLAG_BIT)
        else $error("reset instruction ignored");
    a_err_sticky: assert property (@(posedge MCLK) disable iff (SRST)
        ERROR_FLAG_BIT && !(wr_rise && data_s == fcd_pkg::CMD_RESET) |=> ERROR_FLAG_BIT)
        else $error("error flag cleared without reset instruction");
    a_err_set: assert property (@(posedge MCLK) disable iff (SRST)
        OP_FAIL |=> ERROR_FLAG_BIT)
        else $error("failure did not set error flag");
    a_bypass_hold: assert property (@(posedge MCLK) disable iff (SRST)
        BYPASS_MODE && !(wr_rise && st_q.mode == fcd_pkg::FCD_BYP_RST) |=> BYPASS_MODE)
        else $error("bypass left without bypass reset");
    a_suspend_gate: assert property (@(posedge MCLK) disable iff (SRST)
        !SUSPEND && !st_q.erase_run |=> !SUSPEND)
        else $error("suspend without running erase");
    a_resume_gate: assert property (@(posedge MCLK) disable iff (SRST)
        st_q.mode == fcd_pkg::FCD_READ && !st_q.erase_run |=> st_q.mode != fcd_pkg::FCD_ERASE)
        else $error("resume outside suspend");
    a_win_close: assert property (@(posedge MCLK) disable iff (SRST)
        st_q.win_open && st_q.win_cnt == WIN_LAST && !wr_rise |=> ERASE_GO)
        else $error("erase window did not close on time");
    a_prot_value: assert property (@(posedge MCLK) disable iff (SRST)
        rd_fall && st_q.mode == fcd_pkg::FCD_ID && bits610(addr_s) == fcd_pkg::SEL_PROT
        && !st_q.err |=> RD_DATA == fcd_pkg::PROT_YES || RD_DATA == fcd_pkg::PROT_NO)
        else $error("protection read value wrong");
    a_addr_fall: assert property (@(posedge MCLK) disable iff (SRST)
        wr_fall |=> st_q.cyc.addr == $past(addr_s))
        else $error("address not captured on strobe fall");
    a_id_value: assert property (@(posedge MCLK) disable iff (SRST)
        s_id_read ##0 (bits610(addr_s) == fcd_pkg::SEL_ID && |sel_s[7:0])
        |=> RD_DATA == ID_CODE)
        else $error("identifier read value wrong");
    a_array_read: assert property (@(posedge MCLK) disable iff (SRST)
        rd_fall && st_q.mode == fcd_pkg::FCD_READ && !st_q.err
        |=> RD_DATA == $past(ARRAY_DATA))
        else $error("array read not returned directly");
    a_prog_needs_prefix: assert property (@(posedge MCLK) disable iff (SRST)
        s_wr_in_read |=> !REQ_VALID)
        else $error("program request without command prefix");
    a_abandon_seq: assert property (@(posedge MCLK) disable iff (SRST)
        wr_rise && st_q.mode == fcd_pkg::FCD_U1 && data_s != fcd_pkg::CMD_RESET
        && !hit(st_q.cyc.addr, fcd_pkg::ADR_AAA, data_s, fcd_pkg::DAT_UNLOCK2)
        |=> READ_ARRAY)
        else $error("mismatched write did not abandon sequence");
endmodule

/* File: bench/fcd_backend_model.sv */
// behavioural array back end answering program and erase requests
`timescale 1ns/1ps
module fcd_backend_model #(
    parameter int ERASE_LAT = 150,
    parameter int PROG_LAT = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [fcd_pkg::ADDR_W-1:0] addr,
    input wire logic req_valid,
    input wire fcd_pkg::fcd_req_t req,
    input wire logic erase_go,
    input wire logic suspend,
    input wire logic fail_next,
    output logic [7:0] array_data,
    output logic op_done,
    output logic op_fail
);
    int busy;
    // array byte is a pattern of the address, never a constant
    assign array_data = addr[7:0] ^ 8'h3c;
    always_ff @(posedge clk) begin
        op_done <= 1'b0;
        op_fail <= 1'b0;
        if (rst) begin
            busy <= 0;
        end else if (erase_go || (req_valid && req.bulk)) begin
            busy <= ERASE_LAT;
        end else if (req_valid && req.prog && fail_next) begin
            op_fail <= 1'b1;
        end else if (req_valid && req.prog) begin
            busy <= PROG_LAT;
        end else if (busy > 0 && !suspend) begin
            busy <= busy - 1;
            op_done <= (busy == 1);
        end
    end
endmodule

/* File: bench/tb_flash_command_decoder.sv */
// self-checking bench for the flash command decoder
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_flash_command_decoder;
    localparam logic [7:0] ID = 8'h5a;
    logic mclk = 0;
    logic srst = 1;
    logic wr_n = 1;
    logic rd_n = 1;
    logic [15:0] adr = 16'h0000;
    logic [7:0] din = 8'h00;
    logic [11:0] sel = 12'h000;
    logic [11:0] wsel = 12'h001;
    logic [11:0] prot = 12'h004;
    logic fail_next = 0;
    logic [7:0] arr;
    logic [7:0] rd_data;
    logic [7:0] q;
    logic op_done, op_fail, req_valid, erase_go, suspend, err, byp, rd_arr;
    fcd_pkg::fcd_req_t req;
    fcd_pkg::fcd_req_t last_req;
    int fails = 0;
    int n_checks = 0;
    int n_prog = 0;
    int n_go = 0;
    int i;

    fcd_decoder #(.ERASE_WIN(40), .ID_CODE(ID)) u_fcd_decoder (
        .MCLK(mclk), .SRST(srst), .WR_N(wr_n), .RD_N(rd_n), .ADDR(adr),
        .DATA_IN(din), .MAIN_SECTOR_SELECT(sel[7:0]),
        .SECONDARY_SECTOR_SELECT(sel[11:8]), .ARRAY_DATA(arr),
        .PROTECTED(prot), .OP_DONE(op_done), .OP_FAIL(op_fail), .REQ(req),
        .REQ_VALID(req_valid), .ERASE_GO(erase_go), .SUSPEND(suspend),
        .RD_DATA(rd_data), .ERROR_FLAG_BIT(err), .BYPASS_MODE(byp),
        .READ_ARRAY(rd_arr));
    fcd_backend_model u_fcd_backend_model (
        .clk(mclk), .rst(srst), .addr(adr), .req_valid(req_valid), .req(req),
        .erase_go(erase_go), .suspend(suspend), .fail_next(fail_next),
        .array_data(arr), .op_done(op_done), .op_fail(op_fail));

    initial begin
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (req_valid) n_prog++;
        if (erase_go) n_go++;
        if (req_valid || erase_go) last_req = req;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // address swapped after the fall and data only valid near the rise
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        adr = a;
        din = ~d;
        sel = wsel;
        wr_n = 0;
        cyc(4);
        adr = ~a;
        din = d;
        cyc(4);
        wr_n = 1;
        cyc(4);
        sel = 12'h000;
        cyc(1);
    endtask
    // bench only reads data, it never fetches code from the array it commands
    task automatic rd(input logic [15:0] a, input logic [11:0] s);
        adr = a;
        sel = s;
        rd_n = 0;
        cyc(5);
        q = rd_data;
        rd_n = 1;
        sel = 12'h000;
        cyc(4);
    endtask
    // high address bits set so only bits 11..0 may match
    task automatic unl(input logic [7:0] c);
        wr(16'hf555, 8'haa);
        wr(16'hfaaa, 8'h55);
        wr(16'he555, c);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_ident;
        rd(16'h0041, 12'h001);
        `CHK(q, 8'h41 ^ 8'h3c)
        unl(8'h90);
        rd(16'h0201, 12'h001);
        `CHK(q, ID)
        rd(16'h0202, 12'h004);
        `CHK(q, 8'h01)
        rd(16'h0202, 12'h008);
        `CHK(q, 8'h00)
        wr(16'h7777, 8'hf0);
        `CHK(rd_arr, 1'b1)
        unl(8'h90);
        srst = 1;
        cyc(1);
        srst = 0;
        cyc(1);
        `CHK(rd_arr, 1'b1)
        wr(16'h0555, 8'haa);
        wr(16'h0aaa, 8'h12);
        wr(16'h0555, 8'h90);
        rd(16'h0201, 12'h001);
        `CHK(q, 8'h01 ^ 8'h3c)
        done("ident");
    endtask
    task automatic t_program;
        unl(8'ha0);
        wr(16'h9234, 8'h6b);
        `CHK(last_req.prog, 1'b1)
        `CHK(last_req.addr, 16'h9234)
        `CHK(last_req.data, 8'h6b)
        fail_next = 1;
        unl(8'ha0);
        wr(16'h0010, 8'h00);
        fail_next = 0;
        `CHK(err, 1'b1)
        wr(16'h0000, 8'hf0);
        `CHK(err, 1'b0)
        done("program");
    endtask
    task automatic t_bypass;
        i = n_prog;
        wr(16'h0555, 8'ha0);
        wr(16'h0100, 8'h77);
        `CHK(n_prog, i)
        unl(8'h20);
        `CHK(byp, 1'b1)
        wr(16'h0000, 8'ha0);
        wr(16'h0300, 8'h66);
        `CHK(n_prog, i + 1)
        `CHK(last_req.data, 8'h66)
        wr(16'h0000, 8'hf0);
        `CHK(byp, 1'b1)
        wr(16'h0000, 8'h90);
        wr(16'h0000, 8'h00);
        `CHK(byp, 1'b0)
        `CHK(rd_arr, 1'b1)
        done("bypass");
    endtask
    task automatic t_erase;
        wr(16'h0000, 8'hb0);
        `CHK(suspend, 1'b0)
        unl(8'h80);
        unl(8'h30);
        wsel = 12'h002;
        wr(16'h2000, 8'h30);
        wsel = 12'h001;
        for (i = 0; i < 80 && n_go == 0; i++) cyc(1);
        `CHK(n_go, 1)
        `CHK(last_req.sectors, 12'h003)
        wr(16'h0000, 8'hb0);
        `CHK(suspend, 1'b1)
        wr(16'h0000, 8'h30);
        `CHK(suspend, 1'b0)
        unl(8'h80);
        unl(8'h30);
        wr(16'h4000, 8'h30);
        `CHK(last_req.erase, 1'b1)
        `CHK(n_go, 1)
        for (i = 0; i < 300 && !op_done; i++) cyc(1);
        wr(16'h0000, 8'h30);
        `CHK(n_go, 1)
        `CHK(suspend, 1'b0)
        done("erase");
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #200us;
        fails++;
        complete_run;
    end
    initial begin
        cyc(3);
        srst = 0;
        cyc(1);
        `CHK(rd_arr, 1'b1)
        `CHK(err, 1'b0)
        t_ident;
        t_program;
        t_bypass;
        t_erase;
        complete_run;
    end
endmodule
